// ===== rtl/egm_consts.vh
// Register offsets, reset values, encodings and limits of the electronic gear block
`ifndef EGM_CONSTS_VH
`define EGM_CONSTS_VH
`define EGM_ADDR_METHOD 16'h052e
`define EGM_ADDR_VCAP 16'h2612
`define EGM_ADDR_POLICY 16'h2616
`define EGM_ADDR_OFS_VEL 16'h2708
`define EGM_ADDR_OFFSET_RAMP_RATE 16'h270c
`define EGM_ADDR_OFS_D1 16'h2710
`define EGM_ADDR_OFS_D2 16'h2714
`define EGM_ADDR_RATIO_NUM 16'h2600
`define EGM_ADDR_RATIO_DEN 16'h2604
`define EGM_ADDR_VSCALE_NUM 16'h2620
`define EGM_ADDR_VSCALE_DEN 16'h2624
`define EGM_ADDR_STATUS 16'h2630
`define EGM_METHOD_POS_IMM 16'h0001
`define EGM_METHOD_POS_COMP 16'h0002
`define EGM_METHOD_VEL 16'h0003
`define EGM_RST_METHOD 16'h0001
`define EGM_RST_VCAP 32'h00000000
`define EGM_RST_POLICY 16'h0000
`define EGM_RST_OFS_VEL 32'h0000003c
`define EGM_RST_OFFSET_RAMP_RATE 32'h00000258
`define EGM_RST_RATIO 32'h00000001
`define EGM_OFS_VEL_CAP 32'h00001388
`define EGM_STATE_OP_ENABLED 4'h6
`endif

// ===== rtl/egm_gear.v
// Electronic gear method, disabled-position policy, offset movement and velocity cap
`timescale 1ns/10ps
`include "egm_consts.vh"
// How it works
// - Method field: 1 position immediate, 2 position compensated, 3 velocity; reset 1.
// - New method latched when the motor next starts moving or at a mode start.
// - Policy 0 discards disabled-time position changes; 1 keeps them.
// - Policy matters only when gear was started in compensated method.
// - Policy write takes effect at next power stage enable.
// - Kept changes are compensated on entering operation enabled, state 6.
// - Changes before the first enable after mode start are never compensated.
// - Offset moves only in position methods, never velocity synchronization.
// - Two signed 32-bit offset distances, reset zero, used immediately.
// - Offset moves use own velocity, default 60, and ramp, default 600.
// - Offset velocity capped at 5000 divided by velocity scale factor.
// - Ramp writes refused while enabled; accepted value used at next enable.
// - Velocity profile settings apply only in velocity synchronization.
// - Position methods: cap 0 means none, else limit motor velocity immediately.
// - Motor increments equal reference increments times numerator over denominator.
// - Negative numerator reverses motor direction.
module egm_gear (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] i_addr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata,
  output reg o_ack,
  output reg o_err,
  input wire i_mode_start,
  input wire i_power_enable,
  input wire [3:0] i_op_state,
  input wire i_ref_valid,
  input wire signed [31:0] i_ref_inc,
  input wire signed [31:0] i_motor_fb_inc,
  input wire i_offset1_in,
  input wire i_offset2_in,
  output reg signed [31:0] o_motor_inc,
  output reg o_motor_inc_valid,
  output reg [31:0] o_vel_limit,
  output reg o_vel_limit_en,
  output reg o_vel_profile_en,
  output reg o_offset_busy,
  output reg [31:0] o_offset_vel,
  output reg [31:0] o_offset_ramp,
  output reg [15:0] o_active_method
);
  reg [15:0] method_reg;
  reg [31:0] vcap_reg;
  reg [15:0] policy_reg;
  reg [31:0] ofs_vel_reg;
  reg [31:0] offset_ramp_rate_reg;
  reg signed [31:0] ofs_d1_reg;
  reg signed [31:0] ofs_d2_reg;
  reg signed [31:0] ratio_num_reg;
  reg signed [31:0] ratio_den_reg;
  reg [31:0] vscale_num_reg;
  reg [31:0] vscale_den_reg;
  reg [15:0] act_method_reg;
  reg act_policy_reg;
  reg started_comp_reg;
  reg first_enable_seen_reg;
  reg signed [63:0] pend_reg;
  reg pwr_q_reg;
  reg moving_q_reg;
  reg signed [31:0] ofs_left_reg;
  reg [1:0] in1_sync_reg;
  reg [1:0] in2_sync_reg;
  reg in1_q_reg;
  reg in2_q_reg;
  reg [31:0] cap_next;
  reg signed [31:0] step_next;
  reg signed [31:0] vel_s;
  reg [63:0] cap_wide;
  wire ratio_valid;
  wire signed [31:0] ratio_inc;
  wire enable_rise;
  wire is_pos;
  wire moving;
  wire in1_rise;
  wire in2_rise;
  wire signed [63:0] ratio_inc_wide;
  wire signed [63:0] fb_inc_wide;

  ////////////////////////////////////////////////////////////////
  // Reference scaling
  // Remainder is cleared on a mode start so an old fraction never leaks in
  egm_ratio u_ratio (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(i_mode_start),
    .i_valid(i_ref_valid),
    .i_ref_inc(i_ref_inc),
    .i_num(ratio_num_reg),
    .i_den(ratio_den_reg),
    .o_valid(ratio_valid),
    .o_motor_inc(ratio_inc)
  );

  assign enable_rise = i_power_enable && !pwr_q_reg;
  assign is_pos = (act_method_reg != `EGM_METHOD_VEL);
  assign moving = ratio_valid && (ratio_inc != 32'sh0);
  assign in1_rise = in1_sync_reg[1] && !in1_q_reg;
  assign in2_rise = in2_sync_reg[1] && !in2_q_reg;
  // Sign extended copies for the 64-bit pending sum
  assign ratio_inc_wide = {{32{ratio_inc[31]}}, ratio_inc};
  assign fb_inc_wide = {{32{i_motor_fb_inc[31]}}, i_motor_fb_inc};

  ////////////////////////////////////////////////////////////////
  // Offset velocity ceiling: 5000 * den / num of velocity scale
  // The product is formed at 64 bits so a large denominator cannot wrap;
  // a quotient beyond 32 bits saturates instead of folding to a small ceiling
  always @* begin
    cap_wide = 64'h0;
    if (vscale_num_reg == 32'h0) begin
      cap_next = `EGM_OFS_VEL_CAP;
    end else begin
      cap_wide = {32'h0, `EGM_OFS_VEL_CAP} * {32'h0, vscale_den_reg};
      cap_wide = cap_wide / {32'h0, vscale_num_reg};
      if (cap_wide[63:32] != 32'h0) begin
        cap_next = 32'hffffffff;
      end else begin
        cap_next = cap_wide[31:0];
      end
    end
    vel_s = (ofs_vel_reg > cap_next) ? cap_next : ofs_vel_reg;
    // Offset velocity counts increments per cycle; the ramp is only passed on
    if (ofs_left_reg > 32'sh0) begin
      step_next = (ofs_left_reg > $signed(vel_s)) ? $signed(vel_s) : ofs_left_reg;
    end else if (ofs_left_reg < 32'sh0) begin
      step_next = (-ofs_left_reg > $signed(vel_s)) ? -$signed(vel_s) : ofs_left_reg;
    end else begin
      step_next = 32'sh0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register writes; ramp refused while power stage enabled
  // A refused write leaves the register untouched and answers with err,
  // so a controller can tell a dropped value from a taken one
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      method_reg <= `EGM_RST_METHOD;
      vcap_reg <= `EGM_RST_VCAP;
      policy_reg <= `EGM_RST_POLICY;
      ofs_vel_reg <= `EGM_RST_OFS_VEL;
      offset_ramp_rate_reg <= `EGM_RST_OFFSET_RAMP_RATE;
      ofs_d1_reg <= 32'sh0;
      ofs_d2_reg <= 32'sh0;
      ratio_num_reg <= `EGM_RST_RATIO;
      ratio_den_reg <= `EGM_RST_RATIO;
      vscale_num_reg <= `EGM_RST_RATIO;
      vscale_den_reg <= `EGM_RST_RATIO;
      o_ack <= 1'b0;
      o_err <= 1'b0;
    end else begin
      o_ack <= i_wr || i_rd;
      o_err <= 1'b0;
      if (i_wr) begin
        case (i_addr)
          `EGM_ADDR_METHOD: begin
            if (i_wdata[15:0] >= `EGM_METHOD_POS_IMM && i_wdata[15:0] <= `EGM_METHOD_VEL) begin
              method_reg <= i_wdata[15:0];
            end else begin
              o_err <= 1'b1;
            end
          end
          `EGM_ADDR_VCAP: vcap_reg <= i_wdata;
          `EGM_ADDR_POLICY: begin
            if (i_wdata[15:1] == 15'h0) begin
              policy_reg <= i_wdata[15:0];
            end else begin
              o_err <= 1'b1;
            end
          end
          `EGM_ADDR_OFS_VEL: begin
            if (i_wdata != 32'h0) begin
              ofs_vel_reg <= i_wdata;
            end else begin
              o_err <= 1'b1;
            end
          end
          `EGM_ADDR_OFFSET_RAMP_RATE: begin
            if (i_power_enable || i_wdata == 32'h0) begin
              o_err <= 1'b1;
            end else begin
              offset_ramp_rate_reg <= i_wdata;
            end
          end
          `EGM_ADDR_OFS_D1: ofs_d1_reg <= i_wdata;
          `EGM_ADDR_OFS_D2: ofs_d2_reg <= i_wdata;
          `EGM_ADDR_RATIO_NUM: ratio_num_reg <= i_wdata;
          `EGM_ADDR_RATIO_DEN: begin
            if (i_wdata[31] || i_wdata == 32'h0) begin
              o_err <= 1'b1;
            end else begin
              ratio_den_reg <= i_wdata;
            end
          end
          `EGM_ADDR_VSCALE_NUM: vscale_num_reg <= i_wdata;
          `EGM_ADDR_VSCALE_DEN: vscale_den_reg <= i_wdata;
          default: o_err <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux, registered
  // Data stays until the next read; unmapped offsets read as zero
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `EGM_ADDR_METHOD: o_rdata <= {16'h0, method_reg};
        `EGM_ADDR_VCAP: o_rdata <= vcap_reg;
        `EGM_ADDR_POLICY: o_rdata <= {16'h0, policy_reg};
        `EGM_ADDR_OFS_VEL: o_rdata <= ofs_vel_reg;
        `EGM_ADDR_OFFSET_RAMP_RATE: o_rdata <= offset_ramp_rate_reg;
        `EGM_ADDR_OFS_D1: o_rdata <= ofs_d1_reg;
        `EGM_ADDR_OFS_D2: o_rdata <= ofs_d2_reg;
        `EGM_ADDR_RATIO_NUM: o_rdata <= ratio_num_reg;
        `EGM_ADDR_RATIO_DEN: o_rdata <= ratio_den_reg;
        `EGM_ADDR_VSCALE_NUM: o_rdata <= vscale_num_reg;
        `EGM_ADDR_VSCALE_DEN: o_rdata <= vscale_den_reg;
        `EGM_ADDR_STATUS: o_rdata <= {13'h0, act_policy_reg, o_offset_busy, first_enable_seen_reg,
                                      act_method_reg};
        default: o_rdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Method, policy and ramp latching; pending compensation tracking
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      act_method_reg <= `EGM_RST_METHOD;
      act_policy_reg <= 1'b0;
      started_comp_reg <= 1'b0;
      first_enable_seen_reg <= 1'b0;
      pend_reg <= 64'sh0;
      pwr_q_reg <= 1'b0;
      moving_q_reg <= 1'b0;
      o_offset_ramp <= `EGM_RST_OFFSET_RAMP_RATE;
    end else begin
      pwr_q_reg <= i_power_enable;
      moving_q_reg <= moving;
      // Method swaps on a start of motion or on a mode start, whichever comes first
      if ((moving && !moving_q_reg) || i_mode_start) begin
        act_method_reg <= method_reg;
      end
      // Policy and ramp latch on every enable edge, even one that meets a mode start
      if (enable_rise) begin
        act_policy_reg <= policy_reg[0];
        o_offset_ramp <= offset_ramp_rate_reg;
      end
      if (i_mode_start) begin
        started_comp_reg <= (method_reg == `EGM_METHOD_POS_COMP);
        first_enable_seen_reg <= 1'b0;
        pend_reg <= 64'sh0;
      end else if (enable_rise) begin
        first_enable_seen_reg <= 1'b1;
        pend_reg <= 64'sh0;
      end else if (!i_power_enable) begin
        // Accumulate reference minus feedback only after a first enable
        // Sum kept at 64 bits so a long disabled spell cannot overflow it
        if (first_enable_seen_reg && ratio_valid) begin
          pend_reg <= pend_reg + ratio_inc_wide - fb_inc_wide;
        end else if (first_enable_seen_reg) begin
          pend_reg <= pend_reg - fb_inc_wide;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Offset input sync and remaining distance
  // The pins are asynchronous: two flops stand before the edge detector
  // A trigger while a move still runs is ignored, so no distance is cut short
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      in1_sync_reg <= 2'b00;
      in2_sync_reg <= 2'b00;
      in1_q_reg <= 1'b0;
      in2_q_reg <= 1'b0;
      ofs_left_reg <= 32'sh0;
    end else begin
      in1_sync_reg <= {in1_sync_reg[0], i_offset1_in};
      in2_sync_reg <= {in2_sync_reg[0], i_offset2_in};
      in1_q_reg <= in1_sync_reg[1];
      in2_q_reg <= in2_sync_reg[1];
      if (!i_power_enable || !is_pos) begin
        ofs_left_reg <= 32'sh0;
      end else if (ofs_left_reg == 32'sh0 && in1_rise) begin
        ofs_left_reg <= ofs_d1_reg;
      end else if (ofs_left_reg == 32'sh0 && in2_rise) begin
        ofs_left_reg <= ofs_d2_reg;
      end else begin
        ofs_left_reg <= ofs_left_reg - step_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Motor command: geared increments, offset step, compensation on entering state 6
  // Nothing is commanded outside state 6, so a stray reference pulse is held back
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_motor_inc <= 32'sh0;
      o_motor_inc_valid <= 1'b0;
      o_vel_limit <= 32'h0;
      o_vel_limit_en <= 1'b0;
      o_vel_profile_en <= 1'b0;
      o_offset_busy <= 1'b0;
      o_offset_vel <= `EGM_RST_OFS_VEL;
      o_active_method <= `EGM_RST_METHOD;
    end else begin
      o_active_method <= act_method_reg;
      o_vel_profile_en <= !is_pos;
      o_vel_limit <= vcap_reg;
      o_vel_limit_en <= is_pos && (vcap_reg != 32'h0);
      o_offset_vel <= vel_s;
      o_offset_busy <= (ofs_left_reg != 32'sh0);
      o_motor_inc_valid <= 1'b0;
      o_motor_inc <= 32'sh0;
      if (i_power_enable && i_op_state == `EGM_STATE_OP_ENABLED) begin
        o_motor_inc_valid <= ratio_valid || (step_next != 32'sh0) || enable_rise;
        o_motor_inc <= (ratio_valid ? ratio_inc : 32'sh0) + step_next;
        // Policy 0 never adds the backlog, so disabled-time travel is dropped
        // Only the low word of the backlog goes out; a larger one would need steps
        if (enable_rise && started_comp_reg && act_policy_reg) begin
          o_motor_inc <= (ratio_valid ? ratio_inc : 32'sh0) + step_next + pend_reg[31:0];
        end
      end
    end
  end
endmodule // egm_gear

// ===== rtl/egm_ratio.v
// Reference increment to motor increment scaling with remainder carry
`timescale 1ns/10ps
module egm_ratio (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_clear,
  input wire i_valid,
  input wire signed [31:0] i_ref_inc,
  input wire signed [31:0] i_num,
  input wire signed [31:0] i_den,
  output reg o_valid,
  output reg signed [31:0] o_motor_inc
);
  reg signed [63:0] rem_reg;
  reg signed [63:0] acc;
  reg signed [63:0] quo;
  reg signed [63:0] den_w;

  ////////////////////////////////////////////////////////////////
  // Scale by num/den; remainder is kept so no increment is lost over time
  always @* begin
    den_w = (i_den == 32'sh0) ? 64'sh1 : {{32{i_den[31]}}, i_den};
    acc = rem_reg + i_ref_inc * i_num; // sign of num sets direction
    quo = acc / den_w;
  end

  always @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      rem_reg <= 64'sh0;
      o_valid <= 1'b0;
      o_motor_inc <= 32'sh0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_motor_inc <= quo[31:0];
        rem_reg <= acc - quo * den_w;
      end
    end
  end
endmodule // egm_ratio

// ===== tb/egm_monitor.sv
// Port checker for the gear block
`timescale 1ns/10ps
`include "egm_consts.vh"
module egm_monitor (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_power_enable,
  input wire [3:0] i_op_state,
  input wire o_ack,
  input wire o_err,
  input wire o_motor_inc_valid,
  input wire o_offset_busy,
  input wire [31:0] o_offset_vel,
  input wire [31:0] o_offset_ramp,
  input wire [15:0] o_active_method
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Ramp write while powered, answered by a refusal
  sequence s_ramp_wr_on;
    i_wr && i_addr == `EGM_ADDR_OFFSET_RAMP_RATE && i_power_enable;
  endsequence
  sequence s_refused;
    ##1 (o_ack && o_err);
  endsequence
  // Four cycles of power keep any latching at the enable edge out of view
  sequence s_held_on;
    i_power_enable [*4];
  endsequence
  AST_ACK_TIMING: assert property (o_ack == $past(i_wr || i_rd))
    else $error("ack not one cycle after strobe");
  AST_ERR_WITH_ACK: assert property (o_err |-> o_ack)
    else $error("err without ack");
  AST_RAMP_REFUSED: assert property (s_ramp_wr_on |-> s_refused)
    else $error("ramp write accepted while powered");
  AST_RAMP_HELD: assert property (s_held_on |-> $stable(o_offset_ramp))
    else $error("active ramp changed while powered");
  AST_METHOD_REFUSED: assert property (i_wr && i_addr == `EGM_ADDR_METHOD &&
    (i_wdata == 32'h0 || i_wdata > 32'h3) |=> o_ack && o_err)
    else $error("bad method code accepted");
  AST_METHOD_RANGE: assert property (o_active_method >= 16'h1 && o_active_method <= 16'h3)
    else $error("active method out of range");
  AST_NO_OFS_VEL: assert property ($rose(o_offset_busy) |->
    o_active_method != `EGM_METHOD_VEL)
    else $error("offset started in velocity method");
  AST_OFS_CAP: assert property (o_offset_vel <= `EGM_OFS_VEL_CAP)
    else $error("offset velocity above cap");
  AST_MOTION_ENABLED: assert property (o_motor_inc_valid |-> $past(i_power_enable) &&
    $past(i_op_state) == `EGM_STATE_OP_ENABLED)
    else $error("motor commanded while not enabled");
endmodule // egm_monitor

// ===== tb/egm_partner.sv
// Reference pulse source and motor model for the gear block
`timescale 1ns/10ps
module egm_partner (
  input wire i_clk,
  input wire signed [31:0] i_motor_inc,
  input wire i_motor_inc_valid,
  output reg o_ref_valid,
  output reg signed [31:0] o_ref_inc,
  output reg signed [31:0] o_fb_inc
);
  integer pos;
  initial begin
    o_ref_valid = 1'b0;
    o_ref_inc = 32'sh0;
    o_fb_inc = 32'sh0;
    pos = 0;
  end
  // Motor follows every command; feedback reports only the step just taken
  always @(posedge i_clk) begin
    pos <= (i_motor_inc_valid === 1'b1) ? pos + i_motor_inc : pos;
    o_fb_inc <= (i_motor_inc_valid === 1'b1) ? i_motor_inc : 32'sh0;
  end
  // One reference pulse; released data lines invert so no stale value passes
  task send(input logic signed [31:0] inc);
    begin
      @(negedge i_clk);
      o_ref_valid = 1'b1;
      o_ref_inc = inc;
      @(negedge i_clk);
      o_ref_valid = 1'b0;
      o_ref_inc = ~inc;
    end
  endtask
endmodule // egm_partner

// ===== tb/test_egm_gear.sv
// Self-checking bench for the gear block
`timescale 1ns/10ps
`include "egm_consts.vh"
module test_egm_gear;
  reg i_clk = 1'b0;
  reg i_reset_n = 1'b0;
  reg wr = 1'b0, rd = 1'b0, start = 1'b0, pwr = 1'b0, ofs1 = 1'b0, ofs2 = 1'b0;
  reg [15:0] addr = 16'h0;
  reg [31:0] wdata = 32'h0;
  reg [31:0] q;
  reg e;
  wire [31:0] rdata, vlim, ovel, oramp;
  wire [15:0] meth;
  wire ack, err, mv, vlim_en, prof_en, busy, rv;
  wire signed [31:0] minc, rinc, fb;
  wire [3:0] state = pwr ? 4'h6 : 4'h5;
  integer failures = 0, samples_checked = 0, n, p0;
  always #2.5 i_clk = ~i_clk;
  egm_gear i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_ack(ack), .o_err(err), .i_mode_start(start),
    .i_power_enable(pwr), .i_op_state(state), .i_ref_valid(rv), .i_ref_inc(rinc),
    .i_motor_fb_inc(fb), .i_offset1_in(ofs1), .i_offset2_in(ofs2), .o_motor_inc(minc),
    .o_motor_inc_valid(mv), .o_vel_limit(vlim), .o_vel_limit_en(vlim_en),
    .o_vel_profile_en(prof_en), .o_offset_busy(busy), .o_offset_vel(ovel),
    .o_offset_ramp(oramp), .o_active_method(meth));
  egm_partner i_ptn (.i_clk(i_clk), .i_motor_inc(minc), .i_motor_inc_valid(mv),
    .o_ref_valid(rv), .o_ref_inc(rinc), .o_fb_inc(fb));
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task tick(input integer c);
    repeat (c) @(negedge i_clk);
  endtask
  // One strobe cycle, then a bounded wait for the answer
  task xfer(input w, input [15:0] a, input [31:0] d);
    begin
      @(negedge i_clk);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge i_clk);
      wr = 1'b0;
      rd = 1'b0;
      n = 0;
      while (ack !== 1'b1 && n < 3) begin
        tick(1);
        n = n + 1;
      end
      if (n == 3) begin
        failures = failures + 1;
        complete_run;
      end
      q = rdata;
      e = err;
    end
  endtask
  task wr_reg(input [15:0] a, input [31:0] d, input x);
    begin
      xfer(1'b1, a, d);
      chk("err", {31'h0, x}, {31'h0, e});
    end
  endtask
  task rd_reg(input [15:0] a, input [31:0] x);
    begin
      xfer(1'b0, a, 32'h0);
      chk("rdata", x, q);
    end
  endtask
  task go;
    begin
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(1);
    end
  endtask
  // Reference pulse, then the geared motor travel is compared
  task move(input [31:0] inc, input [31:0] x);
    begin
      p0 = i_ptn.pos;
      i_ptn.send(inc);
      tick(4);
      chk("moved", x, i_ptn.pos - p0);
    end
  endtask
  // Controller pulses an offset input and waits for the move to finish
  task offset(input s, input [31:0] x);
    begin
      p0 = i_ptn.pos;
      ofs1 = !s;
      ofs2 = s;
      tick(4);
      ofs1 = 1'b0;
      ofs2 = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
        tick(1);
        n = n + 1;
      end
      if (n == 100) begin
        failures = failures + 1;
        complete_run;
      end
      tick(3);
      chk("offset", x, i_ptn.pos - p0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    i_reset_n = 1'b1;
    rd_reg(`EGM_ADDR_METHOD, 32'h1);
    rd_reg(`EGM_ADDR_VCAP, 32'h0);
    rd_reg(`EGM_ADDR_POLICY, 32'h0);
    rd_reg(`EGM_ADDR_OFS_VEL, 32'h3c);
    rd_reg(`EGM_ADDR_OFFSET_RAMP_RATE, 32'h258);
    rd_reg(`EGM_ADDR_OFS_D1, 32'h0);
    rd_reg(`EGM_ADDR_OFS_D2, 32'h0);
    chk("ovel", 32'h3c, ovel);
    chk("oramp", 32'h258, oramp);
    $display("test reset values done");
    // Every method code, both sides of the legal range
    for (int c = 0; c < 5; c++) wr_reg(`EGM_ADDR_METHOD, c, c == 0 || c > 3);
    wr_reg(`EGM_ADDR_METHOD, 32'h1, 1'b0);
    wr_reg(`EGM_ADDR_POLICY, 32'h2, 1'b1);
    wr_reg(`EGM_ADDR_OFS_VEL, 32'h0, 1'b1);
    wr_reg(16'h0010, 32'h5, 1'b1);
    rd_reg(16'h0010, 32'h0);
    chk("method", 32'h1, {16'h0, meth});
    $display("test refusals done");
    wr_reg(`EGM_ADDR_RATIO_NUM, 32'hfffffffd, 1'b0);
    wr_reg(`EGM_ADDR_RATIO_DEN, 32'h2, 1'b0);
    go;
    pwr = 1'b1;
    tick(2);
    move(32'h4, 32'hfffffffa);
    move(32'h2, 32'hfffffffd);
    wr_reg(`EGM_ADDR_RATIO_NUM, 32'h1, 1'b0);
    wr_reg(`EGM_ADDR_RATIO_DEN, 32'h1, 1'b0);
    wr_reg(`EGM_ADDR_METHOD, 32'h2, 1'b0);
    chk("method", 32'h1, {16'h0, meth});
    move(32'h3, 32'h3);
    chk("method", 32'h2, {16'h0, meth});
    $display("test gearing done");
    wr_reg(`EGM_ADDR_OFS_D1, 32'h7, 1'b0);
    wr_reg(`EGM_ADDR_OFS_VEL, 32'h3, 1'b0);
    offset(1'b0, 32'h7);
    wr_reg(`EGM_ADDR_OFS_D2, 32'hfffffffc, 1'b0);
    offset(1'b1, 32'hfffffffc);
    wr_reg(`EGM_ADDR_OFS_VEL, 32'h1388, 1'b0);
    wr_reg(`EGM_ADDR_VSCALE_NUM, 32'h2, 1'b0);
    tick(2);
    chk("ovel", 32'h9c4, ovel);
    wr_reg(`EGM_ADDR_VCAP, 32'h32, 1'b0);
    tick(2);
    chk("vlim", 32'h32, vlim);
    chk("vlim_en", 32'h1, {31'h0, vlim_en});
    wr_reg(`EGM_ADDR_VCAP, 32'h0, 1'b0);
    tick(2);
    chk("vlim_en", 32'h0, {31'h0, vlim_en});
    $display("test offsets and caps done");
    wr_reg(`EGM_ADDR_OFFSET_RAMP_RATE, 32'h64, 1'b1);
    pwr = 1'b0;
    wr_reg(`EGM_ADDR_OFFSET_RAMP_RATE, 32'h64, 1'b0);
    chk("oramp", 32'h258, oramp);
    pwr = 1'b1;
    tick(3);
    chk("oramp", 32'h64, oramp);
    $display("test ramp done");
    // Disabled-time travel: never before the first enable, kept after it only in compensated method
    pwr = 1'b0;
    wr_reg(`EGM_ADDR_POLICY, 32'h1, 1'b0);
    go;
    move(32'h4, 32'h0);
    pwr = 1'b1;
    tick(4);
    chk("comp", 32'h0, i_ptn.pos - p0);
    pwr = 1'b0;
    move(32'ha, 32'h0);
    pwr = 1'b1;
    tick(4);
    chk("comp", 32'ha, i_ptn.pos - p0);
    wr_reg(`EGM_ADDR_METHOD, 32'h1, 1'b0);
    pwr = 1'b0;
    go;
    pwr = 1'b1;
    tick(2);
    pwr = 1'b0;
    move(32'ha, 32'h0);
    pwr = 1'b1;
    tick(4);
    chk("comp", 32'h0, i_ptn.pos - p0);
    $display("test compensation done");
    wr_reg(`EGM_ADDR_METHOD, 32'h3, 1'b0);
    go;
    tick(2);
    chk("method", 32'h3, {16'h0, meth});
    chk("prof_en", 32'h1, {31'h0, prof_en});
    offset(1'b0, 32'h0);
    $display("test velocity method done");
    complete_run;
  end
endmodule // test_egm_gear
bind egm_gear egm_monitor i_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(i_wr),
  .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_power_enable(i_power_enable),
  .i_op_state(i_op_state), .o_ack(o_ack), .o_err(o_err), .o_motor_inc_valid(o_motor_inc_valid),
  .o_offset_busy(o_offset_busy), .o_offset_vel(o_offset_vel), .o_offset_ramp(o_offset_ramp),
  .o_active_method(o_active_method));
